// ---- pkg/swc_consts.svh ----
// Purpose: Constants for the SYSREF window capture block.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Offsets, field positions and reset values live here only.
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
`define SWC_NUM_TAPS      24
`define SWC_SEL_TAPS      16
`define SWC_ADDR_POS_LO   8'h2c
`define SWC_ADDR_POS_MID  8'h2d
`define SWC_ADDR_POS_HI   8'h2e
`define SWC_ADDR_CTRL     8'h30
`define SWC_ADDR_PER_LO   8'h31
`define SWC_ADDR_PER_HI   8'h32
`define SWC_ADDR_STAT     8'h33
`define SWC_CTRL_SEL_LSB  0
`define SWC_CTRL_SEL_MSB  3
`define SWC_CTRL_FINE_BIT 4
`define SWC_CTRL_FMT_BIT  5
`define SWC_STAT_SEEN_BIT 0
`define SWC_STAT_MEAS_BIT 1
`define SWC_CTRL_RST      8'h10
`define SWC_PERIOD_RST    16'h0100
`define SWC_POS_RST       24'hffffff
`endif

// ---- pkg/swc_pkg.sv ----
// Purpose: Types shared by the SYSREF window capture files.
// Assumes: Constants come from the consts header.
// Notes:   Bus requests and control settings travel as packed structs.
package swc_pkg;
    typedef logic [7:0] swc_byte_t;
    typedef struct packed {
        logic [7:0] addr;
        swc_byte_t  wdata;
        logic       wr;
        logic       rd;
    } swc_bus_req_s;
    typedef struct packed {
        logic [3:0]  tap_sel;
        logic        fine;
        logic        fmt64;
        logic [15:0] period;
    } swc_ctrl_s;
    typedef enum logic [1:0] {
        SWC_ST_IDLE = 2'b00,
        SWC_ST_LOW  = 2'b01,
        SWC_ST_HIGH = 2'b10
    } swc_cap_e;
endpackage

// ---- logic/swc_tap_line.sv ----
// Purpose: Per-tap violation detector over the delayed SYSREF samples.
// Assumes: Tap samples are synchronous to sys_clk, tap 0 the least delay.
// Notes:   A tap next to a level change between neighbours is marked.
`timescale 1ns/1ns
`include "swc_consts.svh"
module swc_tap_line
    import swc_pkg::*;
#(
    parameter int NUM_TAPS = `SWC_NUM_TAPS
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic [NUM_TAPS-1:0] taps,
    output logic      [NUM_TAPS-1:0] window_vec,
    output logic                     window_event
);
    logic [NUM_TAPS-1:0] prev_reg;

    // Previous samples, used to spot the arrival of a SYSREF edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= taps;
        end
    end

    // An edge arrived when all taps were low and some tap now is high.
    assign window_event = (prev_reg == '0) && (taps != '0);

    // End taps are always suspect; inner taps flag a neighbour change.
    for (genvar k = 0; k < NUM_TAPS; k++) begin : g_tap
        // R11 end taps set
        if (k == 0 || k == NUM_TAPS - 1) begin : g_end
            assign window_vec[k] = 1'b1;
        end else begin : g_mid
            // R6 neighbour change risk
            assign window_vec[k] = (taps[k] ^ taps[k-1]) | (taps[k] ^ taps[k+1]);
        end
    end
endmodule

// ---- logic/swc_frame_counter.sv ----
// Purpose: Local multiframe or extended multiblock clock counter.
// Assumes: Software programs the period in device clock cycles.
// Notes:   A restart pulse zeroes the count on the next edge.
`timescale 1ns/1ns
module swc_frame_counter
    import swc_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] period,
    input  wire logic         restart,
    output logic      [W-1:0] count,
    output logic              boundary
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         wrap;

    // A period of zero or one wraps every cycle.
    assign wrap       = (period <= W'(1)) || (count_reg >= period - W'(1));
    assign count_next = (restart || wrap) ? '0 : count_reg + W'(1);
    assign count      = count_reg;
    assign boundary   = (count_reg == '0);

    // Count register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule

// ---- logic/swc_top.sv ----
// Purpose: SYSREF window capture with tap selection and status readback.
// Assumes: Tap samples come from an external delay line, one bit per tap.
// Notes:   Registers sit on a byte-wide port with read data one cycle late.
`timescale 1ns/1ns
`include "swc_consts.svh"

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// R1 - SYSREF may arrive as one pulse or as a periodic signal.
// R2 - A periodic SYSREF runs at the frame clock rate or a whole division.
// R3 - SYSREF is captured on a deterministic clock edge after each start.
// R4 - Clock and SYSREF are applied before status is read or a tap is set.
// R5 - The SYSREF position in the clock cycle is stored per tap.
// R6 - A status bit is 1 for a risky tap and 0 for a valid one.
// R7 - SYSREF is sampled at the selected delayed clock instance.
// R8 - The tap select value is the decimal index of the chosen status bit.
// R9 - Twenty-four positions are read over three bytes, smallest delay first.
// R10 - Only the first sixteen taps can be selected.
// R11 - Status bits 0 and 23 always read as 1.
// R12 - Zoom 0 gives coarse tap steps and zoom 1 gives fine steps.
// R13 - Software keeps fine steps unless no transition region shows.
// R14 - Software picks the tap midway between violations, lower preferred.
// R15 - The captured SYSREF resets the frame clock counter.
// R16 - Status keeps updating and reads have no side effects.
module swc_top
    import swc_pkg::*;
#(
    parameter int NUM_TAPS = `SWC_NUM_TAPS,
    parameter int PER_W    = 16
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire swc_bus_req_s        bus_req,
    output logic      [7:0]          rd_data,
    input  wire logic [NUM_TAPS-1:0] tap_samples,
    output logic                     delay_fine_step,
    output logic                     link_fmt_64b66b,
    output logic                     sysref_captured,
    output logic      [PER_W-1:0]    frame_count,
    output logic                     frame_boundary
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

    swc_ctrl_s           ctrl_reg;
    swc_ctrl_s           ctrl_next;
    logic [NUM_TAPS-1:0] pos_reg;
    logic [NUM_TAPS-1:0] pos_next;
    logic [7:0]          rd_data_reg;
    logic [7:0]          rd_data_next;
    swc_cap_e            state_reg;
    swc_cap_e            state_next;
    logic                cap_reg;
    logic                cap_next;
    logic                seen_reg;
    logic                seen_next;
    logic                meas_reg;
    logic                meas_next;
    logic [NUM_TAPS-1:0] window_vec;
    logic                window_event;
    logic                sel_sample;
    logic                wr_ctrl;
    logic                wr_per_lo;
    logic                wr_per_hi;
    logic                wr_stat;
    logic [7:0]          ctrl_byte;
    logic [7:0]          stat_byte;
    logic [7:0]          rd_mux;

    // Control reset value as a named constant, so that its fields can be picked out.
    localparam logic [7:0] CTRL_RST_VAL = `SWC_CTRL_RST;

////////////////////////////////////////////////////////////////////////////////
// Window measurement

    // Per-tap comparison of the delayed SYSREF samples.
    swc_tap_line #(
        .NUM_TAPS     (NUM_TAPS)
    ) u_tap_line (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .taps         (tap_samples),
        .window_vec   (window_vec),
        .window_event (window_event)
    );

    // R5 store window position
    // R16 refresh per edge
    assign pos_next = window_event ? window_vec : pos_reg;

    // Status vector, refreshed on every arriving SYSREF edge.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pos_reg <= `SWC_POS_RST;
        end else begin
            pos_reg <= pos_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Register writes

    // Write decode; each strobe selects one register by address.
    assign wr_ctrl   = bus_req.wr && (bus_req.addr == `SWC_ADDR_CTRL);
    assign wr_per_lo = bus_req.wr && (bus_req.addr == `SWC_ADDR_PER_LO);
    assign wr_per_hi = bus_req.wr && (bus_req.addr == `SWC_ADDR_PER_HI);
    assign wr_stat   = bus_req.wr && (bus_req.addr == `SWC_ADDR_STAT);

    // R10 four-bit select
    assign ctrl_next.tap_sel = wr_ctrl ?
        bus_req.wdata[`SWC_CTRL_SEL_MSB:`SWC_CTRL_SEL_LSB] : ctrl_reg.tap_sel;
    // R12 zoom control
    assign ctrl_next.fine  = wr_ctrl ? bus_req.wdata[`SWC_CTRL_FINE_BIT] : ctrl_reg.fine;
    assign ctrl_next.fmt64 = wr_ctrl ? bus_req.wdata[`SWC_CTRL_FMT_BIT] : ctrl_reg.fmt64;
    // Period is written one byte at a time.
    assign ctrl_next.period[7:0]  = wr_per_lo ? bus_req.wdata : ctrl_reg.period[7:0];
    assign ctrl_next.period[15:8] = wr_per_hi ? bus_req.wdata : ctrl_reg.period[15:8];

    // Control register with its reset defaults.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_reg.tap_sel <= 4'(`SWC_CTRL_RST >> `SWC_CTRL_SEL_LSB);
            ctrl_reg.fine    <= CTRL_RST_VAL[`SWC_CTRL_FINE_BIT];
            ctrl_reg.fmt64   <= CTRL_RST_VAL[`SWC_CTRL_FMT_BIT];
            ctrl_reg.period  <= `SWC_PERIOD_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Tap spacing and format go straight out of the control register.
    assign delay_fine_step = ctrl_reg.fine;
    assign link_fmt_64b66b = ctrl_reg.fmt64;

////////////////////////////////////////////////////////////////////////////////
// SYSREF capture

    // R7 delayed instance
    // R8 index selects tap
    assign sel_sample = tap_samples[ctrl_reg.tap_sel];

    // R1 pulse or periodic
    // R3 deterministic edge
    always_comb begin
        state_next = state_reg;
        cap_next   = 1'b0;
        case (state_reg)
            SWC_ST_IDLE: begin
                if (!sel_sample) begin
                    state_next = SWC_ST_LOW;
                end
            end
            SWC_ST_LOW: begin
                if (sel_sample) begin
                    state_next = SWC_ST_HIGH;
                    cap_next   = 1'b1;
                end
            end
            SWC_ST_HIGH: begin
                if (!sel_sample) begin
                    state_next = SWC_ST_LOW;
                end
            end
            default: begin
                state_next = SWC_ST_IDLE;
            end
        endcase
    end

    // Capture state and the one-cycle capture pulse.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= SWC_ST_IDLE;
            cap_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cap_reg   <= cap_next;
        end
    end

    assign sysref_captured = cap_reg;

    // R15 counter restart
    swc_frame_counter #(
        .W        (PER_W)
    ) u_frame_counter (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .period   (ctrl_reg.period),
        .restart  (cap_reg),
        .count    (frame_count),
        .boundary (frame_boundary)
    );

////////////////////////////////////////////////////////////////////////////////
// Status flags

    // A capture sets the seen flag; the set wins over a write-one clear.
    assign seen_next = cap_reg ||
        (seen_reg && !(wr_stat && bus_req.wdata[`SWC_STAT_SEEN_BIT]));
    // The measured flag rises on the first window update and stays.
    assign meas_next = meas_reg || window_event;

    // Sticky status flags.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            seen_reg <= 1'b0;
            meas_reg <= 1'b0;
        end else begin
            seen_reg <= seen_next;
            meas_reg <= meas_next;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Register reads

    // Packed views of control and status for readback.
    assign ctrl_byte = {2'b00, ctrl_reg.fmt64, ctrl_reg.fine, ctrl_reg.tap_sel};
    assign stat_byte = {4'h0, state_reg, meas_reg, seen_reg};

    // R9 three status bytes
    assign rd_mux =
        (bus_req.addr == `SWC_ADDR_POS_LO)  ? pos_reg[7:0]            :
        (bus_req.addr == `SWC_ADDR_POS_MID) ? pos_reg[15:8]           :
        (bus_req.addr == `SWC_ADDR_POS_HI)  ? pos_reg[23:16]          :
        (bus_req.addr == `SWC_ADDR_CTRL)    ? ctrl_byte               :
        (bus_req.addr == `SWC_ADDR_PER_LO)  ? ctrl_reg.period[7:0]    :
        (bus_req.addr == `SWC_ADDR_PER_HI)  ? ctrl_reg.period[15:8]   :
        (bus_req.addr == `SWC_ADDR_STAT)    ? stat_byte               :
                                              8'h00;

    // Read data stand only in the cycle after the strobe.
    assign rd_data_next = bus_req.rd ? rd_mux : 8'h00;

    // Read data register.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

////////////////////////////////////////////////////////////////////////////////
// Checks

    // End taps never read as valid.
    a_end_taps_set: assert property ( // R11
        @(posedge sys_clk) disable iff (!rst_n)
        pos_reg[0] && pos_reg[NUM_TAPS-1])
        else $error("End tap status bit is clear.");

    // Status follows the vector measured on the arriving edge.
    a_window_update: assert property ( // R5 R6
        @(posedge sys_clk) disable iff (!rst_n)
        window_event |=> pos_reg == $past(window_vec))
        else $error("Status vector missed a window update.");

    // Without an arriving edge the status holds.
    a_window_hold: assert property ( // R16
        @(posedge sys_clk) disable iff (!rst_n)
        !window_event |=> $stable(pos_reg))
        else $error("Status vector changed without an edge.");

    // A read of the high status byte returns it one cycle later.
    a_status_read: assert property ( // R9
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && bus_req.addr == `SWC_ADDR_POS_HI
        |=> rd_data == $past(pos_reg[23:16]))
        else $error("High status byte read back wrong.");

    // Reads leave the control register untouched.
    a_read_no_effect: assert property ( // R16
        @(posedge sys_clk) disable iff (!rst_n)
        bus_req.rd && !bus_req.wr |=> ctrl_reg == $past(ctrl_reg))
        else $error("A read changed the control setting.");

    // Tap spacing follows the written zoom bit.
    a_zoom_follow: assert property ( // R12
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ctrl |=> delay_fine_step == $past(bus_req.wdata[`SWC_CTRL_FINE_BIT]))
        else $error("Tap spacing does not follow the zoom bit.");

    // A capture comes from a rise on the selected tap after a low.
    a_capture_cause: assert property ( // R7 R8
        @(posedge sys_clk) disable iff (!rst_n)
        sysref_captured |->
        $past(tap_samples[ctrl_reg.tap_sel]) && $past(state_reg) == SWC_ST_LOW)
        else $error("Capture without a rise on the selected tap.");

    // One capture per SYSREF edge, never two in a row.
    a_capture_single: assert property ( // R3 R1
        @(posedge sys_clk) disable iff (!rst_n)
        sysref_captured |=> !sysref_captured)
        else $error("Capture pulse lasted more than one cycle.");

    // The frame counter restarts right after a capture.
    a_counter_reset: assert property ( // R15
        @(posedge sys_clk) disable iff (!rst_n)
        sysref_captured |=> frame_count == '0 && frame_boundary)
        else $error("Frame counter did not restart on capture.");

    // A control write sets the tap index on the next edge.
    a_ctrl_select: assert property ( // R8
        @(posedge sys_clk) disable iff (!rst_n)
        wr_ctrl |=> ctrl_reg.tap_sel ==
        $past(bus_req.wdata[`SWC_CTRL_SEL_MSB:`SWC_CTRL_SEL_LSB]))
        else $error("Tap select does not follow the written index.");

    // A period write lands in the low byte on the next edge.
    a_period_write: assert property ( // R15
        @(posedge sys_clk) disable iff (!rst_n)
        wr_per_lo |=> ctrl_reg.period[7:0] == $past(bus_req.wdata))
        else $error("Low period byte does not follow the write.");

    // A capture always sets the seen flag.
    a_seen_set: assert property ( // R3
        @(posedge sys_clk) disable iff (!rst_n)
        cap_reg |=> seen_reg)
        else $error("Capture did not set the seen flag.");

    // A write-one clear without a capture drops the seen flag.
    a_seen_clear: assert property ( // R3
        @(posedge sys_clk) disable iff (!rst_n)
        wr_stat && bus_req.wdata[`SWC_STAT_SEEN_BIT] && !cap_reg |=> !seen_reg)
        else $error("Seen flag survived its clear.");

    // Without a read strobe the read data return to zero.
    a_read_idle: assert property ( // R9
        @(posedge sys_clk) disable iff (!rst_n)
        !bus_req.rd |=> rd_data == 8'h00)
        else $error("Read data stood without a read.");

    // Once a window was measured, the measured flag stays set.
    a_meas_sticky: assert property ( // R5
        @(posedge sys_clk) disable iff (!rst_n)
        meas_reg |=> meas_reg)
        else $error("Measured flag dropped.");

    // Between captures the frame counter steps by one until it wraps.
    a_counter_step: assert property ( // R15
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n && !cap_reg && ctrl_reg.period > 16'h0001 &&
        frame_count < ctrl_reg.period - 16'h0001
        |=> frame_count == $past(frame_count) + 16'h0001)
        else $error("Frame counter skipped a step.");
endmodule

// ---- verification/swc_clock_source.sv ----
// Purpose: Behavioural clock source that drives SYSREF onto the tap samples.
// Assumes: Each bit of taps is SYSREF as one delayed clock tap sees it.
// Notes:   A pulse holds its pattern for high_cycles, then all taps go low.
`timescale 1ns/1ns
module swc_clock_source (
    input  wire logic        sys_clk,
    input  wire logic        fire,
    input  wire logic        periodic,
    input  wire logic [23:0] pattern,
    input  wire logic [7:0]  high_cycles,
    input  wire logic [15:0] period_cycles,
    output logic      [23:0] taps
);
    logic [15:0] age_reg = 16'hffff;
    logic        restart;

    ////////////////////////////////////////////////////////////////////////
    // single or periodic
    // A fire starts a pulse; in periodic mode it repeats every period.
    assign restart = fire || (periodic && (age_reg == period_cycles - 16'h0001));

    // clock and SYSREF first
    // Outside periodic mode the age saturates, so the taps stay low until the next fire.
    always @(posedge sys_clk) begin
        if (restart) begin
            age_reg <= 16'h0000;
        end else if (age_reg != 16'hffff) begin
            age_reg <= age_reg + 16'h0001;
        end
    end

    // Taps show the pattern while the pulse is high, zero otherwise.
    assign taps = (age_reg < {8'h00, high_cycles}) ? pattern : 24'h000000;
endmodule

// ---- verification/tb_swc_top.sv ----
// Purpose: Self-checking bench for the SYSREF window capture block.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Status expectations use the neighbour-change window measure.
`timescale 1ns/1ns
module tb_swc_top
    import swc_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         rst_n   = 1'b0;
    swc_bus_req_s bus_req = '0;
    logic [7:0]   rd_data;
    logic [23:0]  taps;
    logic         delay_fine_step;
    logic         link_fmt_64b66b;
    logic         sysref_captured;
    logic [15:0]  frame_count;
    logic         frame_boundary;
    logic         fire     = 1'b0;
    logic         periodic = 1'b0;
    logic [23:0]  pattern  = '0;
    int           err_count = 0;
    int           cmp_count = 0;
    int           cap_count = 0;
    int           n0;

    // Clock at 250 MHz.
    always #2 sys_clk = ~sys_clk;

    swc_top swc_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
        .rd_data(rd_data), .tap_samples(taps), .delay_fine_step(delay_fine_step),
        .link_fmt_64b66b(link_fmt_64b66b), .sysref_captured(sysref_captured),
        .frame_count(frame_count), .frame_boundary(frame_boundary));

    swc_clock_source swc_clock_source_inst (.sys_clk(sys_clk), .fire(fire),
        .periodic(periodic), .pattern(pattern), .high_cycles(8'h02),
        .period_cycles(16'h0008), .taps(taps));

    // Counts every capture pulse seen by the bench.
    always @(posedge sys_clk) begin
        if (sysref_captured === 1'b1) begin
            cap_count++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 check(rd_data, exp);
        @(posedge sys_clk);
        #1 check(rd_data, 24'h0);
    endtask

    // Expected window: a tap differing from a neighbour is risky; ends always set.
    function automatic logic [23:0] win(input logic [23:0] t);
        logic [23:0] v;
        v = 24'h800001;
        for (int k = 1; k < 23; k++) begin
            v[k] = (t[k] != t[k-1]) || (t[k] != t[k+1]);
        end
        return v;
    endfunction

    task automatic rd_status(input logic [23:0] e);
        rd_chk(8'h2c, e[7:0]);
        rd_chk(8'h2d, e[15:8]);
        rd_chk(8'h2e, e[23:16]);
    endtask

    // Fires one SYSREF pulse and checks capture timing, counter and status.
    task automatic pulse(input logic [23:0] p, input logic hit, input logic [23:0] st);
        n0 = cap_count;
        @(posedge sys_clk);
        fire    <= 1'b1;
        pattern <= p;
        @(posedge sys_clk);
        fire <= 1'b0;
        @(posedge sys_clk);
        #1 check(sysref_captured, {23'h0, hit});
        for (int i = 0; i < 5 && hit; i++) begin
            @(posedge sys_clk);
            #1 check(frame_count, 24'(i % 4));
            check(frame_boundary, {23'h0, i % 4 == 0});
        end
        repeat (4) @(posedge sys_clk);
        check(24'(cap_count - n0), {23'h0, hit});
        rd_status(st);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog cuts a hang short.
    initial begin
        #100000;
        err_count++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 check(delay_fine_step, 24'h1);
        check(frame_boundary, 24'h1);
        rd_status(24'hffffff);
        rd_chk(8'h30, 8'h10);
        rd_chk(8'h31, 8'h00);
        rd_chk(8'h32, 8'h01);
        rd_chk(8'h40, 8'h00);
        wr(8'h2c, 8'h00);
        rd_chk(8'h2c, 8'hff);
        wr(8'h30, 8'h25);
        #1 check(delay_fine_step, 24'h0);
        check(link_fmt_64b66b, 24'h1);
        rd_chk(8'h30, 8'h25);
        wr(8'h30, 8'h17);
        #1 check(delay_fine_step, 24'h1);
        wr(8'h31, 8'h04);
        wr(8'h32, 8'h00);
        pulse(24'h000ff0, 1'b1, win(24'h000ff0));
        wr(8'h30, 8'h13);
        pulse(24'h000ff0, 1'b0, win(24'h000ff0));
        wr(8'h30, 8'h1f);
        rd_chk(8'h30, 8'h1f);
        pulse(24'hffff00, 1'b1, win(24'hffff00));
        // Periodic SYSREF every eight cycles gives one capture per period.
        wr(8'h30, 8'h15);
        n0 = cap_count;
        @(posedge sys_clk);
        fire     <= 1'b1;
        periodic <= 1'b1;
        pattern  <= 24'h00fff0;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (62) @(posedge sys_clk);
        periodic <= 1'b0;
        #1 check(24'(cap_count - n0), 24'h8);
        repeat (4) @(posedge sys_clk);
        rd_status(win(24'h00fff0));
        rd_chk(8'h33, 8'h07);
        wr(8'h33, 8'h01);
        rd_chk(8'h33, 8'h06);
        complete_run();
    end
endmodule
